// ---- design/arsr_pkg.sv ----
// Package: offsets, field layout and carriers of the ADC result registers
package arsr_pkg;
  localparam logic [7:0] INT_STAT_OFS = 8'h8c;
  localparam logic [7:0] RES_BASE_OFS = 8'h90;
  localparam logic [7:0] RES_LAST_OFS = 8'hd4;
  localparam logic [7:0] RES_STRIDE = 8'h04;
  localparam logic [31:0] RES_RST = 32'h0000_0000;
  localparam logic [31:0] RD_IDLE = 32'h0000_0000;
  // Result word fields
  localparam int LSB_POS = 28;
  localparam int TU_POS = 26;
  localparam int DOF_POS = 25;
  localparam int SO_POS = 24;
  localparam int CO_POS = 23;
  localparam int GAIN_POS = 20;
  localparam int FILT_POS = 19;
  localparam int EN_POS = 16;
  localparam int ERR_POS = 14;
  localparam int DATA_POS = 0;
  // Interrupt status fields
  localparam int CCC_POS = 31;
  localparam int TUC_POS = 30;
  localparam int DOFC_POS = 29;
  localparam int SOC_POS = 28;
  localparam int COC_POS = 27;
  localparam int MAX_CH = 18;

  // Report handed over by the filter at the end of a conversion
  typedef struct packed {
    logic [3:0] lsb;
    logic [11:0] data;
    logic [2:0] gain;
    logic filt;
    logic trig_busy;
    logic sinc4_ovr;
    logic coi_ovr;
    logic stale;
  } arsr_conv_t;

  // Stored contents of one channel's result register
  typedef struct packed {
    logic [3:0] lsb;
    logic [11:0] data;
    logic [2:0] gain;
    logic filt;
    logic tu;
    logic modulator_overload_short;
    logic so;
    logic co;
    logic err;
  } arsr_ent_t;
endpackage

// ---- design/arsr_result_regs.sv ----
// Per-channel conversion result and status registers with interrupt status
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
// How it works
// - One result word per channel, 0x90 to 0xD4
// - New conversion always overwrites the channel's word
// - Bits 31-28 hold four low counter bits
// - Bit 26 flags trigger during running conversion
// - Bit 25 copies latched modulator overload flag
// - Bit 24 flags second filter range violation
// - Bit 23 flags first filter range violation
// - Bits 22-20 hold gain of that conversion
// - Bit 19 shows which decimation filter used
// - Bit 16 shows channel's current enable setting
// - Bit 14 ORs errors, cleared by read
// - Status read during completion cycle is invalid
// - Read clears status and matching pending bit
// - Read never alters the conversion result
// - One pending bit per channel, read clears
// - Bit 31 set when any channel completed
module arsr_result_regs #(
  parameter int NUM_CH = 18,
  parameter int CH_W = 5
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [31:0] BUS_RDATA,
  input wire logic CONV_DONE,
  input wire logic [CH_W-1:0] CONV_CH,
  input wire arsr_pkg::arsr_conv_t CONV_RPT,
  input wire logic MOD_OVL,
  input wire logic [NUM_CH-1:0] CH_EN
);

  if (NUM_CH < 1 || NUM_CH > arsr_pkg::MAX_CH || (2 ** CH_W) < NUM_CH)
  begin : g_bad_cfg
    $error("arsr_result_regs: NUM_CH or CH_W out of range");
  end

  arsr_pkg::arsr_ent_t ent_ff [NUM_CH];
  arsr_pkg::arsr_ent_t nxt_ent [NUM_CH];
  logic [NUM_CH-1:0] done_ff;
  logic [NUM_CH-1:0] nxt_done;
  logic [31:0] rdata_ff;
  logic [31:0] word [NUM_CH];
  logic [31:0] rd_chain [NUM_CH+1];
  logic [NUM_CH-1:0] sel;
  logic [NUM_CH-1:0] rd_clr;
  logic [NUM_CH-1:0] hit_done;
  logic [NUM_CH-1:0] tu_vec;
  logic [NUM_CH-1:0] dof_vec;
  logic [NUM_CH-1:0] so_vec;
  logic [NUM_CH-1:0] co_vec;
  logic int_sel;
  logic [31:0] int_word;
  logic [31:0] rd_word;
  logic conv_err;

  // The write strobe and data are taken but nothing is writable
  wire unused_wr = BUS_WR ^ (^BUS_WDATA);

  assign int_sel = BUS_ADDR == arsr_pkg::INT_STAT_OFS;
  assign conv_err = CONV_RPT.trig_busy | MOD_OVL | CONV_RPT.sinc4_ovr
                  | CONV_RPT.coi_ovr | CONV_RPT.stale;
  assign rd_chain[0] = 32'h0000_0000;

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    localparam logic [7:0] OFS = arsr_pkg::RES_BASE_OFS + 8'(i) * arsr_pkg::RES_STRIDE;

    assign sel[i] = BUS_ADDR == OFS;
    assign rd_clr[i] = BUS_RD & sel[i];
    assign hit_done[i] = CONV_DONE & (CONV_CH == CH_W'(i));

    // Completion beats a read in the same cycle, so no event is lost
    always_comb
    begin
      nxt_ent[i] = ent_ff[i];
      if (hit_done[i])
      begin
        nxt_ent[i].lsb = CONV_RPT.lsb;
        nxt_ent[i].data = CONV_RPT.data;
        nxt_ent[i].gain = CONV_RPT.gain;
        nxt_ent[i].filt = CONV_RPT.filt;
        nxt_ent[i].tu = CONV_RPT.trig_busy;
        nxt_ent[i].modulator_overload_short = MOD_OVL;
        nxt_ent[i].so = CONV_RPT.sinc4_ovr;
        nxt_ent[i].co = CONV_RPT.coi_ovr;
        nxt_ent[i].err = conv_err;
      end
      else if (rd_clr[i])
      begin
        // Result and gain survive; only the flags clear
        nxt_ent[i].tu = 1'b0;
        nxt_ent[i].modulator_overload_short = 1'b0;
        nxt_ent[i].so = 1'b0;
        nxt_ent[i].co = 1'b0;
        nxt_ent[i].err = 1'b0;
      end
    end

    assign nxt_done[i] = hit_done[i] | (done_ff[i] & ~rd_clr[i]);

    always_ff @(posedge REF_CLK)
    begin
      if (!RST_N)
      begin
        ent_ff[i] <= '0;
        done_ff[i] <= 1'b0;
      end
      else
      begin
        ent_ff[i] <= nxt_ent[i];
        done_ff[i] <= nxt_done[i];
      end
    end

    // Reserved bits stay zero by construction
    assign word[i] = (32'(ent_ff[i].lsb) << arsr_pkg::LSB_POS)
                   | (32'(ent_ff[i].tu) << arsr_pkg::TU_POS)
                   | (32'(ent_ff[i].modulator_overload_short) << arsr_pkg::DOF_POS)
                   | (32'(ent_ff[i].so) << arsr_pkg::SO_POS)
                   | (32'(ent_ff[i].co) << arsr_pkg::CO_POS)
                   | (32'(ent_ff[i].gain) << arsr_pkg::GAIN_POS)
                   | (32'(ent_ff[i].filt) << arsr_pkg::FILT_POS)
                   | (32'(CH_EN[i]) << arsr_pkg::EN_POS)
                   | (32'(ent_ff[i].err) << arsr_pkg::ERR_POS)
                   | (32'(ent_ff[i].data) << arsr_pkg::DATA_POS);
    assign rd_chain[i+1] = rd_chain[i] | (sel[i] ? word[i] : 32'h0000_0000);
    assign tu_vec[i] = ent_ff[i].tu;
    assign dof_vec[i] = ent_ff[i].modulator_overload_short;
    assign so_vec[i] = ent_ff[i].so;
    assign co_vec[i] = ent_ff[i].co;

    result_load_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> ent_ff[i].data == $past(CONV_RPT.data))
      else $error("result not loaded on completion");

    low_bits_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> word[i][31:28] == $past(CONV_RPT.lsb))
      else $error("low counter bits wrong");

    trig_flag_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> word[i][26] == $past(CONV_RPT.trig_busy))
      else $error("trigger flag wrong");

    ovl_copy_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] ##1 !rd_clr[i] |-> word[i][25] == $past(MOD_OVL))
      else $error("overload copy wrong");

    range_flags_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> word[i][24:23] == {$past(CONV_RPT.sinc4_ovr), $past(CONV_RPT.coi_ovr)})
      else $error("filter range flags wrong");

    gain_filt_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> word[i][22:19] == {$past(CONV_RPT.gain), $past(CONV_RPT.filt)})
      else $error("gain or filter field wrong");

    err_or_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> word[i][14] == $past(conv_err))
      else $error("error bit not OR of causes");

    read_clear_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] && !hit_done[i] |=> word[i][26:23] == 4'h0 && !word[i][14] && !done_ff[i])
      else $error("read did not clear status");

    keep_data_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] && !hit_done[i] |=> $stable(word[i][11:0]) && $stable(word[i][31:28]))
      else $error("read altered result");

    set_wins_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] && hit_done[i] |=> done_ff[i] && int_word[i])
      else $error("completion lost to read");

    no_write_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        BUS_WR && !hit_done[i] && !rd_clr[i] |=> $stable(ent_ff[i]))
      else $error("write changed result");

    reset_zero_a:
      assert property (@(posedge REF_CLK)
        !RST_N |=> ent_ff[i] == '0 && !done_ff[i])
      else $error("reset left state");

    hold_state_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !hit_done[i] && !rd_clr[i] |=> $stable(ent_ff[i]))
      else $error("result changed with no event");

    pend_set_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        hit_done[i] |=> done_ff[i])
      else $error("pending bit not set");

    pend_clear_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] && !hit_done[i] |=> !int_word[i])
      else $error("pending bit not cleared by read");

    pend_hold_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        done_ff[i] && !rd_clr[i] |=> done_ff[i])
      else $error("pending bit lost");

    pend_quiet_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        !done_ff[i] && !hit_done[i] |=> !done_ff[i])
      else $error("pending bit set with no completion");

    race_data_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] && hit_done[i] |=> word[i][11:0] == $past(CONV_RPT.data) && word[i][14] == $past(conv_err))
      else $error("completion lost to same cycle read");

    keep_gain_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] && !hit_done[i] |=> $stable(word[i][22:19]))
      else $error("read altered gain or filter");

    map_read_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] |=> BUS_RDATA == $past(word[i]))
      else $error("wrong word returned for channel");

    en_live_a:
      assert property (@(posedge REF_CLK) disable iff (!RST_N)
        rd_clr[i] |=> BUS_RDATA[16] == $past(CH_EN[i]))
      else $error("enable bit not live");
  end

  // Combined flags gathered across all channels
  assign int_word = (32'(|done_ff) << arsr_pkg::CCC_POS)
                  | (32'(|tu_vec) << arsr_pkg::TUC_POS)
                  | (32'(|dof_vec) << arsr_pkg::DOFC_POS)
                  | (32'(|so_vec) << arsr_pkg::SOC_POS)
                  | (32'(|co_vec) << arsr_pkg::COC_POS)
                  | 32'(done_ff);

  // Unmapped addresses fall through the chain and read zero
  assign rd_word = int_sel ? int_word : rd_chain[NUM_CH];

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      rdata_ff <= arsr_pkg::RD_IDLE;
    else if (BUS_RD)
      rdata_ff <= rd_word;
    else
      rdata_ff <= arsr_pkg::RD_IDLE;
  end

  assign BUS_RDATA = rdata_ff;

  comb_done_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (|hit_done) |=> int_word[arsr_pkg::CCC_POS])
    else $error("combined done bit missing");

  read_data_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      BUS_RD && int_sel |=> BUS_RDATA == $past(int_word)
        ##1 (BUS_RDATA == 32'h0 || $past(BUS_RD)))
    else $error("read data not one cycle later");

  idle_zero_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !BUS_RD |=> BUS_RDATA == 32'h0)
    else $error("read data not zero when idle");

  unmapped_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      BUS_RD && !int_sel && !(|sel) |=> BUS_RDATA == 32'h0)
    else $error("unmapped read not zero");

  rsvd_read_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      BUS_RD && (|sel) |=> (BUS_RDATA & 32'h0806_b000) == 32'h0)
    else $error("reserved bits not zero");

  stat_noclr_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      BUS_RD && int_sel && !(|hit_done) |=> $stable(done_ff))
    else $error("status read changed pending bits");

  wr_noeff_a:
    assert property (@(posedge REF_CLK) disable iff (!RST_N)
      BUS_WR && !(|hit_done) |=> $stable(done_ff))
    else $error("write changed pending bits");

endmodule // arsr_result_regs

// ---- verification/arsr_cpu_model.sv ----
// Processor core model issuing register bus reads and writes
`timescale 1ns/10ps
module arsr_cpu_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Data taken mid-cycle so the registered answer has settled
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
endmodule // arsr_cpu_model

// ---- verification/arsr_result_regs_tb.sv ----
// Testbench for the ADC result register bank
`timescale 1ns/10ps
module arsr_result_regs_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic conv_done = 1'b0;
  logic [4:0] conv_ch = 5'h00;
  arsr_pkg::arsr_conv_t conv_rpt = '0;
  arsr_pkg::arsr_conv_t c;
  arsr_pkg::arsr_conv_t c2;
  logic mod_ovl = 1'b0;
  logic [17:0] ch_en = 18'h3ffff;
  int miscompares = 0;
  int n_tests = 0;

  always #25 ref_clk = ~ref_clk;

  arsr_cpu_model cpu (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  arsr_result_regs DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .BUS_ADDR(addr),
    .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata), .CONV_DONE(conv_done),
    .CONV_CH(conv_ch), .CONV_RPT(conv_rpt), .MOD_OVL(mod_ovl), .CH_EN(ch_en));

  // Expected word; f=0 models flags already cleared by a read
  function automatic logic [31:0] ew(arsr_pkg::arsr_conv_t k, logic o, logic e, logic f);
    ew = {k.lsb, 1'b0, f & k.trig_busy, f & o, f & k.sinc4_ovr, f & k.coi_ovr, k.gain,
      k.filt, 2'b00, e, 1'b0, f & (k.trig_busy | o | k.sinc4_ovr | k.coi_ovr | k.stale),
      2'b00, k.data};
  endfunction

  function automatic arsr_pkg::arsr_conv_t mk(int i);
    mk = '0;
    mk.data = 12'h100 + 12'(i);
    mk.gain = 3'(i);
    mk.lsb = 4'(i);
  endfunction

  task automatic cv(input logic [4:0] ch, input arsr_pkg::arsr_conv_t k, input logic o);
    @(posedge ref_clk);
    conv_done <= 1'b1;
    conv_ch <= ch;
    conv_rpt <= k;
    mod_ovl <= o;
  endtask

  task automatic cv_end;
    @(posedge ref_clk);
    conv_done <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    cpu.rd_reg(a, got);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #100000;
    miscompares++;
    end_sim;
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(8'h90, 32'h0001_0000);
    rc(8'h8c, 32'h0);
    $display("test reset done");
    c = '{4'ha, 12'habc, 3'd5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    cv(5'd3, c, 1'b1);
    cv_end;
    rc(8'h8c, 32'hf800_0008);
    rc(8'h9c, ew(c, 1'b1, 1'b1, 1'b1));
    rc(8'h9c, ew(c, 1'b1, 1'b1, 1'b0));
    rc(8'h8c, 32'h0);
    @(posedge ref_clk);
    ch_en[3] <= 1'b0;
    rc(8'h9c, ew(c, 1'b1, 1'b0, 1'b0));
    @(posedge ref_clk);
    ch_en[3] <= 1'b1;
    cpu.wr_reg(8'h9c, 32'hffff_ffff);
    rc(8'h9c, ew(c, 1'b1, 1'b1, 1'b0));
    rc(8'hd8, 32'h0);
    $display("test flags done");
    c2 = '{4'h5, 12'h123, 3'd2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    cv(5'd17, c, 1'b0);
    cv(5'd17, c2, 1'b0);
    cv(5'd18, c, 1'b1);
    cv_end;
    rc(8'h8c, 32'h8002_0000);
    rc(8'hd4, ew(c2, 1'b0, 1'b1, 1'b1));
    $display("test overwrite done");
    for (int i = 0; i < 18; i++)
      cv(5'(i), mk(i), 1'b0);
    cv_end;
    rc(8'h8c, 32'h8003_ffff);
    for (int i = 0; i < 18; i++)
      rc(8'h90 + 8'(4 * i), ew(mk(i), 1'b0, 1'b1, 1'b1));
    $display("test map done");
    fork
      rc(8'h90, ew(mk(0), 1'b0, 1'b1, 1'b1));
      begin
        cv(5'd0, c, 1'b0);
        cv_end;
      end
    join
    rc(8'h8c, 32'hd800_0001);
    rc(8'h90, ew(c, 1'b0, 1'b1, 1'b1));
    $display("test race done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(8'hd4, 32'h0001_0000);
    rc(8'h90, 32'h0001_0000);
    $display("test reset again done");
    end_sim;
  end
endmodule // arsr_result_regs_tb
